//--- include/pagp_consts.vh
// register offsets, field positions, reset values and pin count for the port a block
// assumes the includer works on an apb slave with 32-bit data and byte addressing
// What this block does
// - input pins read back the synchronised pin level in the data register
// - output pins read back the last written data bit
// - every data write with byte lane 0 strobe set updates all eight stored bits
// - output pins drive the stored data bit
// - reset clears data, makes all pins inputs, pulls off
// - direction 0 is input with driver off, 1 drives; resets to 0
// - pull enable turns on pull device, forced off on outputs
// - pull-down only when pin select and edge select ask for interrupt
// - slew enable limits output slew, no effect on inputs, resets 0
// - drive select 0 low drive, 1 high drive, outputs only
// - interrupt flag bit 3 sets on detection, writes cannot change it
// - writing 1 to acknowledge bit 2 clears flag; reads as 0
// - interrupt enable bit 1 gates the request
// - mode bit 0 selects edge only or edge and level
// - edges found synchronously from deasserted then asserted samples
// - edge select 0 falling/low with pull-up, 1 rising/high with pull-down
// - in level mode acknowledge clears only if enabled inputs deasserted
// - pin select 1 enables pin as interrupt source, 0 excludes
`ifndef PAGP_CONSTS_VH
`define PAGP_CONSTS_VH

`define PAGP_NPINS 8
`define PAGP_ADDR_W 12
`define PAGP_OFF_DATA 12'h000
`define PAGP_OFF_DIR 12'h004
`define PAGP_OFF_PULL 12'h008
`define PAGP_OFF_SLEW 12'h00C
`define PAGP_OFF_DRIVE 12'h010
`define PAGP_OFF_ISC 12'h014
`define PAGP_OFF_PSEL 12'h018
`define PAGP_OFF_EDGE 12'h01C
`define PAGP_RST8 8'h00
`define PAGP_BIT_FLAG 3
`define PAGP_BIT_ACK 2
`define PAGP_BIT_IE 1
`define PAGP_BIT_MODE 0
`define PAGP_ZERO24 24'h000000

`endif

//--- tb/pagp_pad_model.sv
// pad model of the eight port a pins
// assumes outside drive comes from the bench on ext_en and ext_val
`timescale 1ns/1ps
module pagp_pad_model (
    input wire pclk,
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire [7:0] pull_on,
    input wire [7:0] pull_down,
    input wire [7:0] ext_val,
    input wire [7:0] ext_en,
    output logic [7:0] pin_level
);
    logic [7:0] float_v = 8'h55;
    // a floating pin flips every cycle so no value passes by chance
    always @(posedge pclk) begin
        float_v <= ~float_v;
    end
    // design driver wins, then outside drive, then pull, else floating
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pull_on[i] ? ~pull_down[i] : float_v[i];
        end
    end
endmodule // pagp_pad_model

//--- tb/pagp_port_properties.sv
// checker: apb answer timing and pad control relations of port a
// assumes binding to pagp_port, one pclk domain, presetn async low
`timescale 1ns/1ps
`include "pagp_consts.vh"
module pagp_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire pslverr,
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire [7:0] pull_on,
    input wire [7:0] pull_down,
    input wire [7:0] slew_on,
    input wire [7:0] drive_high,
    input wire irq_req
);
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a completed write, cause of every later pad change and of any request drop
    wire wr_done = psel & penable & pwrite & pready;
    sequence setup_s; psel && !penable; endsequence
    sequence answer_s; pready ##1 !pready; endsequence
    ready_timing_a: assert property (setup_s |=> answer_s) else $error("pready not one cycle after setup");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    drive_gate_a: assert property ((pin_out & ~pin_oe) == 8'h00) else $error("input pin driven");
    pull_output_a: assert property ((pull_on & pin_oe) == 8'h00) else $error("pull on output");
    pull_down_a: assert property ((pull_down & ~pull_on) == 8'h00) else $error("pull-down without pull");
    slew_gate_a: assert property ((slew_on & ~pin_oe) == 8'h00) else $error("slew on input");
    drive_input_a: assert property ((drive_high & ~pin_oe) == 8'h00) else $error("drive on input");
    dir_change_a: assert property ($changed(pin_oe) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("oe changed without write");
    irq_drop_a: assert property ($fell(irq_req) |-> $past(wr_done) || $past(wr_done, 2)
        || $past(wr_done, 3) || $past(wr_done, 4)) else $error("request fell without write");
    // reset must hold pads quiet, so no disable here
    reset_pads_a: assert property (disable iff (1'b0) !presetn |-> (pin_oe | pull_on) == 8'h00 && !irq_req)
        else $error("pads active in reset");
endmodule // pagp_chk
bind pagp_port pagp_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe), .pull_on(pull_on),
    .pull_down(pull_down), .slew_on(slew_on), .drive_high(drive_high), .irq_req(irq_req));

//--- tb/tb.sv
// self-checking bench for port a: apb tasks and pin stimulus
// assumes pagp_port, pad model and bound checker compiled first
`timescale 1ns/1ps
`include "pagp_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic [3:0] pstrb = 4'hF;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq_req;
    logic [7:0] pin_in, pin_out, pin_oe, pull_on, pull_down, slew_on, drive_high;
    logic [7:0] ext_val = 8'hA5, ext_en = 8'hFF;
    int err_total = 0, samples_checked = 0;
    pagp_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_on(pull_on), .pull_down(pull_down),
        .slew_on(slew_on), .drive_high(drive_high), .irq_req(irq_req));
    pagp_pad_model pad_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_on(pull_on),
        .pull_down(pull_down), .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_in));
    initial begin
        forever #2 pclk = ~pclk;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_total++;
            results();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic e;
        apb(1'b1, a, d, e);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] x, input logic xe);
        logic e;
        apb(1'b0, a, 8'h00, e);
        `CHK(rd, {24'h000000, x})
        `CHK(e, xe)
    endtask
    // pin timing: two sync stages plus flag and request stages
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    initial begin
        // a real falling edge, so the async reset branches fire at time zero
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(pin_oe | pull_on, 8'h00)
        `CHK({pin_out, irq_req}, 9'h000)
        // two synchroniser stages before the pin level can reach a read
        idle(2);
        rchk(`PAGP_OFF_DATA, 8'hA5, 1'b0);
        for (int i = 1; i < 8; i++) rchk(12'(4 * i), 8'h00, 1'b0);
        rchk(12'h020, 8'h00, 1'b1);
        $display("test reset done");
        wr(`PAGP_OFF_SLEW, 8'hFF);
        wr(`PAGP_OFF_DATA, 8'h3C);
        wr(`PAGP_OFF_DIR, 8'hFF);
        idle(2);
        `CHK(pin_out, 8'h3C)
        wr(`PAGP_OFF_DIR, 8'h0F);
        wr(`PAGP_OFF_PULL, 8'hFF);
        wr(`PAGP_OFF_DRIVE, 8'h55);
        rchk(`PAGP_OFF_DATA, 8'hAC, 1'b0);
        `CHK(pin_out, 8'h0C)
        `CHK(pin_oe, 8'h0F)
        `CHK(pull_on, 8'hF0)
        `CHK(slew_on, 8'h0F)
        `CHK(drive_high, 8'h05)
        // read at once: the pin level has not yet passed the synchroniser
        wr(`PAGP_OFF_DATA, 8'h39);
        rchk(`PAGP_OFF_DATA, 8'hA9, 1'b0);
        // byte lane 0 strobe low: the write must be ignored
        pstrb <= 4'h0;
        wr(`PAGP_OFF_DIR, 8'hFF);
        pstrb <= 4'hF;
        rchk(`PAGP_OFF_DIR, 8'h0F, 1'b0);
        $display("test port done");
        wr(`PAGP_OFF_PSEL, 8'hF0);
        wr(`PAGP_OFF_EDGE, 8'h30);
        idle(2);
        `CHK(pull_down, 8'h30)
        wr(`PAGP_OFF_ISC, 8'h06);
        idle(6);
        rchk(`PAGP_OFF_ISC, 8'h02, 1'b0);
        ext_val <= 8'hB5;
        idle(6);
        rchk(`PAGP_OFF_ISC, 8'h0A, 1'b0);
        `CHK(irq_req, 1'b1)
        wr(`PAGP_OFF_ISC, 8'h00);
        idle(4);
        rchk(`PAGP_OFF_ISC, 8'h08, 1'b0);
        `CHK(irq_req, 1'b0)
        // a 1 written to the flag position must not hold or set the flag
        wr(`PAGP_OFF_ISC, 8'h0E);
        // pin 7 leaves the sources, then falls: no flag may follow
        wr(`PAGP_OFF_PSEL, 8'h70);
        ext_val <= 8'h34;
        idle(6);
        rchk(`PAGP_OFF_ISC, 8'h02, 1'b0);
        wr(`PAGP_OFF_ISC, 8'h03);
        idle(6);
        rchk(`PAGP_OFF_ISC, 8'h0B, 1'b0);
        wr(`PAGP_OFF_ISC, 8'h07);
        idle(6);
        rchk(`PAGP_OFF_ISC, 8'h0B, 1'b0);
        ext_val <= 8'hC4;
        wr(`PAGP_OFF_ISC, 8'h07);
        idle(6);
        rchk(`PAGP_OFF_ISC, 8'h03, 1'b0);
        $display("test irq done");
        results();
    end
endmodule // tb

//--- verilog/pagp_irq.v
// pin interrupt detector: edge or edge-and-level, flag, acknowledge
// assumes pins already synchronised to pclk
`timescale 1ns/1ps
`include "pagp_consts.vh"
module pagp_irq (
    input wire pclk,
    input wire presetn,
    input wire [`PAGP_NPINS-1:0] pin_sync,
    input wire [`PAGP_NPINS-1:0] irq_pin_select_bits,
    input wire [`PAGP_NPINS-1:0] edge_polarity_bits,
    input wire detect_mode,
    input wire ack_pulse,
    output reg irq_flag
);
    reg [`PAGP_NPINS-1:0] prev_asserted;
    wire [`PAGP_NPINS-1:0] asserted;
    wire [`PAGP_NPINS-1:0] edge_hit;
    wire level_hit;
    wire detect;
    // ---------------------------------------------
    // detection
    // ---------------------------------------------
    // polarity folded so 1 means asserted level
    assign asserted = (pin_sync ~^ edge_polarity_bits) & irq_pin_select_bits;
    assign edge_hit = asserted & ~prev_asserted;
    assign level_hit = |asserted;
    assign detect = detect_mode ? level_hit : (|edge_hit);
    // previous sample; deselected pins held deasserted so enabling a pin
    // that already sits asserted will flag, hence the init sequence
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_asserted <= `PAGP_RST8;
        end else begin
            prev_asserted <= asserted;
        end
    end
    // flag: set wins over acknowledge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag <= 1'b0;
        end else if (detect) begin
            irq_flag <= 1'b1;
        end else if (ack_pulse) begin
            irq_flag <= 1'b0;
        end
    end
endmodule // pagp_irq

//--- verilog/pagp_port.v
// port a top: apb register file, pin drivers, pad controls, interrupt request
// assumes apb master on pclk, pads resolve level from out/oe/pull signals
`timescale 1ns/1ps
`include "pagp_consts.vh"
module pagp_port (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PAGP_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [`PAGP_NPINS-1:0] pin_in,
    output reg [`PAGP_NPINS-1:0] pin_out,
    output reg [`PAGP_NPINS-1:0] pin_oe,
    output reg [`PAGP_NPINS-1:0] pull_on,
    output reg [`PAGP_NPINS-1:0] pull_down,
    output reg [`PAGP_NPINS-1:0] slew_on,
    output reg [`PAGP_NPINS-1:0] drive_high,
    output reg irq_req
);
    // ---------------------------------------------
    // registers
    // ---------------------------------------------
    reg [`PAGP_NPINS-1:0] pin_data_bits;
    reg [`PAGP_NPINS-1:0] direction_bits;
    reg [`PAGP_NPINS-1:0] pull_enable_bits;
    reg [`PAGP_NPINS-1:0] slew_enable_bits;
    reg [`PAGP_NPINS-1:0] drive_strength_bits;
    reg [`PAGP_NPINS-1:0] irq_pin_select_bits;
    reg [`PAGP_NPINS-1:0] edge_polarity_bits;
    reg irq_enable;
    reg detect_mode;
    reg ack_pulse;
    wire irq_flag;
    wire [`PAGP_NPINS-1:0] pin_sync;
    wire wr_en;
    wire rd_en;
    wire lane0;
    reg [`PAGP_NPINS-1:0] next_rdata;
    reg next_err;

    // decodes an offset into a mapped/unmapped answer
    function is_mapped;
        input [`PAGP_ADDR_W-1:0] a;
        begin
            case (a)
                `PAGP_OFF_DATA, `PAGP_OFF_DIR, `PAGP_OFF_PULL, `PAGP_OFF_SLEW,
                `PAGP_OFF_DRIVE, `PAGP_OFF_ISC, `PAGP_OFF_PSEL, `PAGP_OFF_EDGE: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // ---------------------------------------------
    // submodules
    // ---------------------------------------------
    pagp_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    pagp_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .pin_sync(pin_sync),
        .irq_pin_select_bits(irq_pin_select_bits),
        .edge_polarity_bits(edge_polarity_bits),
        .detect_mode(detect_mode),
        .ack_pulse(ack_pulse),
        .irq_flag(irq_flag)
    );

    // ---------------------------------------------
    // apb access
    // ---------------------------------------------
    // zero wait state: pready is registered from every setup cycle, so it is high in the first access cycle and access ends at once
    assign wr_en = psel & penable & pwrite & pready;
    assign rd_en = psel & ~penable & ~pwrite;
    // only byte lane 0 carries bits; other lanes are ignored
    assign lane0 = pstrb[0];

    // read mux for the byte at paddr
    always @* begin
        next_rdata = `PAGP_RST8;
        next_err = ~is_mapped(paddr);
        case (paddr)
            `PAGP_OFF_DATA: next_rdata = (direction_bits & pin_data_bits) | (~direction_bits & pin_sync);
            `PAGP_OFF_DIR: next_rdata = direction_bits;
            `PAGP_OFF_PULL: next_rdata = pull_enable_bits;
            `PAGP_OFF_SLEW: next_rdata = slew_enable_bits;
            `PAGP_OFF_DRIVE: next_rdata = drive_strength_bits;
            // acknowledge bit always reads 0
            `PAGP_OFF_ISC: begin
                next_rdata[`PAGP_BIT_FLAG] = irq_flag;
                next_rdata[`PAGP_BIT_IE] = irq_enable;
                next_rdata[`PAGP_BIT_MODE] = detect_mode;
            end
            `PAGP_OFF_PSEL: next_rdata = irq_pin_select_bits;
            `PAGP_OFF_EDGE: next_rdata = edge_polarity_bits;
            default: next_rdata = `PAGP_RST8;
        endcase
    end

    // bus answer flops; read data captured in setup, held through access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= {`PAGP_ZERO24, `PAGP_RST8};
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & next_err;
            if (rd_en) begin
                prdata <= {`PAGP_ZERO24, next_rdata};
            end
        end
    end

    // ---------------------------------------------
    // register writes
    // ---------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_data_bits <= `PAGP_RST8;
            direction_bits <= `PAGP_RST8;
            pull_enable_bits <= `PAGP_RST8;
            slew_enable_bits <= `PAGP_RST8;
            drive_strength_bits <= `PAGP_RST8;
            irq_pin_select_bits <= `PAGP_RST8;
            edge_polarity_bits <= `PAGP_RST8;
            irq_enable <= 1'b0;
            detect_mode <= 1'b0;
            ack_pulse <= 1'b0;
        end else begin
            ack_pulse <= 1'b0;
            if (wr_en && lane0) begin
                case (paddr)
                    `PAGP_OFF_DATA: pin_data_bits <= pwdata[7:0];
                    `PAGP_OFF_DIR: direction_bits <= pwdata[7:0];
                    `PAGP_OFF_PULL: pull_enable_bits <= pwdata[7:0];
                    `PAGP_OFF_SLEW: slew_enable_bits <= pwdata[7:0];
                    `PAGP_OFF_DRIVE: drive_strength_bits <= pwdata[7:0];
                    // flag bit ignored on write
                    `PAGP_OFF_ISC: begin
                        irq_enable <= pwdata[`PAGP_BIT_IE];
                        detect_mode <= pwdata[`PAGP_BIT_MODE];
                        ack_pulse <= pwdata[`PAGP_BIT_ACK];
                    end
                    `PAGP_OFF_PSEL: irq_pin_select_bits <= pwdata[7:0];
                    `PAGP_OFF_EDGE: edge_polarity_bits <= pwdata[7:0];
                    default: ack_pulse <= 1'b0;
                endcase
            end
        end
    end

    // ---------------------------------------------
    // pad controls and request, all registered
    // ---------------------------------------------
    // one cycle after the register; pads do not need combinational speed
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= `PAGP_RST8;
            pin_oe <= `PAGP_RST8;
            pull_on <= `PAGP_RST8;
            pull_down <= `PAGP_RST8;
            slew_on <= `PAGP_RST8;
            drive_high <= `PAGP_RST8;
            irq_req <= 1'b0;
        end else begin
            pin_out <= pin_data_bits & direction_bits;
            pin_oe <= direction_bits;
            pull_on <= pull_enable_bits & ~direction_bits;
            pull_down <= irq_pin_select_bits & edge_polarity_bits & pull_enable_bits & ~direction_bits;
            slew_on <= slew_enable_bits & direction_bits;
            drive_high <= drive_strength_bits & direction_bits;
            irq_req <= irq_flag & irq_enable;
        end
    end
endmodule // pagp_port

//--- verilog/pagp_sync.v
// two-stage synchroniser for the eight port pins
// assumes the pins are asynchronous to pclk
`timescale 1ns/1ps
`include "pagp_consts.vh"
module pagp_sync (
    input wire pclk,
    input wire presetn,
    input wire [`PAGP_NPINS-1:0] async_in,
    output reg [`PAGP_NPINS-1:0] sync_out
);
    reg [`PAGP_NPINS-1:0] meta;
    // ---------------------------------------------
    // two flops; only the second stage is read
    // ---------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= `PAGP_RST8;
            sync_out <= `PAGP_RST8;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // pagp_sync
